// File: design/ubb_pkg.sv
// Package: register map, field positions and carriers of the USB bus bridge registers
package ubb_pkg;
	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [11:0] ubb_off_int_status = 12'h000;
	localparam logic [11:0] ubb_off_int_enable = 12'h004;
	localparam logic [11:0] ubb_off_mw_timeout = 12'h008;
	localparam logic [11:0] ubb_off_core_setting = 12'h00C;
	localparam logic [11:0] ubb_off_master_setting = 12'h010;
	localparam logic [11:0] ubb_off_br_rd_req = 12'h014;
	localparam logic [11:0] ubb_off_br_rd_val = 12'h018;
	localparam logic [11:0] ubb_off_core_rd_req = 12'h01C;
	localparam logic [11:0] ubb_off_core_rd_val = 12'h020;
	localparam logic [11:0] ubb_off_arbiter_setting = 12'h03C;
	localparam logic [11:0] ubb_off_wr_start = 12'h040;
	localparam logic [11:0] ubb_off_wr_end = 12'h044;
	localparam logic [11:0] ubb_off_wr_current = 12'h048;
	localparam logic [11:0] ubb_off_wr_bus_addr = 12'h04C;
	localparam logic [11:0] ubb_off_rd_start = 12'h050;
	localparam logic [11:0] ubb_off_rd_end = 12'h054;
	localparam logic [11:0] ubb_off_rd_current = 12'h058;
	localparam logic [11:0] ubb_off_rd_bus_addr = 12'h05C;
	localparam logic [11:0] ubb_off_power_ctl = 12'h080;
	localparam logic [11:0] ubb_off_master_status = 12'h084;
	localparam logic [11:0] ubb_off_timeout_count = 12'h088;
	// Bridge window ends here; offsets 0x200 upward reach the core
	localparam logic [11:0] ubb_core_base = 12'h200;
	// ****************************************************************
	// Interrupt status bit positions
	// ****************************************************************
	localparam int ubb_bit_usb_reset = 9;
	localparam int ubb_bit_rd_bus_err = 23;
	localparam int ubb_bit_br_rd_done = 25;
	localparam int ubb_bit_core_done = 24;
	localparam int ubb_bit_power = 28;
	localparam int ubb_bit_wr_ep_err = 29;
	// Bits that exist as status flags; the others read as zero
	localparam logic [31:0] ubb_status_mask = 32'h33800200;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] ubb_rst_zero = 32'h00000000;
	// Bridge read request: bit 31 start, bits 7:0 byte offset
	localparam int ubb_req_go_bit = 31;
	// Value of an undefined upper half of a core word
	localparam logic [15:0] ubb_core_upper = 16'h0000;
	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic req;
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
	} ubb_core_req_s;
	typedef struct packed {
		logic done;
		logic [15:0] rdata;
	} ubb_core_rsp_s;
	typedef struct packed {
		logic wr_ep_err;
		logic rd_bus_err;
		logic usb_reset;
	} ubb_events_s;
endpackage

// File: design/ubb_core_port.sv
// Core access port: one request at a time toward the device core
`timescale 1ns/1ns
module ubb_core_port
	import ubb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic start_wr,
	input wire logic [7:0] start_addr,
	input wire logic [15:0] start_wdata,
	output logic busy,
	output logic finished,
	output logic [15:0] result,
	output ubb_core_req_s core_req,
	input wire ubb_core_rsp_s core_rsp
);
	// ****************************************************************
	// Request hold
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_req <= '0;
			busy <= 1'b0;
		end else if (start && !busy) begin
			core_req <= '{req: 1'b1, wr: start_wr, addr: start_addr, wdata: start_wdata};
			busy <= 1'b1;
		end else if (busy && core_rsp.done) begin
			core_req.req <= 1'b0;
			busy <= 1'b0;
		end
	end
	// ****************************************************************
	// Completion and data latch
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			finished <= 1'b0;
			result <= 16'h0000;
		end else begin
			finished <= busy && core_rsp.done;
			if (busy && core_rsp.done && !core_req.wr) begin
				result <= core_rsp.rdata;
			end
		end
	end
endmodule

// File: design/ubb_regs.sv
// Bridge register file, core forwarding and interrupt status of the USB bus bridge
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module ubb_regs
	import ubb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic bus_power_detect_input,
	input wire ubb_events_s events,
	input wire logic [31:0] wr_current_addr,
	input wire logic [31:0] rd_current_addr,
	input wire logic [31:0] wr_bus_addr,
	input wire logic [31:0] rd_bus_addr,
	input wire logic [31:0] master_state,
	input wire logic [31:0] timeout_counter,
	output logic [31:0] mw_timeout,
	output logic [31:0] core_setting,
	output logic [31:0] master_setting_reg,
	output logic [31:0] arbiter_setting,
	output logic [31:0] wr_start,
	output logic [31:0] wr_end,
	output logic [31:0] rd_start,
	output logic [31:0] rd_end,
	output logic [31:0] power_ctl,
	output ubb_core_req_s core_req,
	input wire ubb_core_rsp_s core_rsp
);
	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic setup;
	logic core_area;
	logic wr_ok;
	logic [31:0] int_status;
	logic [31:0] int_enable;
	logic [31:0] bridge_read_request_reg;
	logic [31:0] bridge_read_value_reg;
	logic [31:0] core_read_request;
	logic [15:0] core_result;
	logic port_busy;
	logic port_done;
	logic port_start;
	logic rd_pending;
	logic core_wait;
	logic [2:0] pwr_sync;
	logic pwr_level;
	logic usb_reset_d;
	logic [31:0] next_status;
	logic [31:0] sel_value;

	assign setup = psel && !penable;
	assign core_area = paddr >= ubb_core_base;
	assign wr_ok = psel && penable && pwrite && pready;
	assign port_start = setup && core_area && !port_busy;

	ubb_core_port u_port (
		.pclk(pclk),
		.presetn(presetn),
		.start(port_start),
		.start_wr(pwrite),
		.start_addr(paddr[9:2]),
		.start_wdata(pwdata[15:0]),
		.busy(port_busy),
		.finished(port_done),
		.result(core_result),
		.core_req(core_req),
		.core_rsp(core_rsp)
	);

	// ****************************************************************
	// Bus handshake: bridge registers answer with no wait cycle, core
	// accesses wait for the port to finish
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			core_wait <= 1'b0;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (setup && !core_area) begin
				pready <= 1'b1;
			end else if (port_start) begin
				core_wait <= 1'b1;
			end else if (core_wait && port_done) begin
				core_wait <= 1'b0;
				pready <= 1'b1;
			end
			if (pready) begin
				pready <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read data mux
	// ****************************************************************
	always_comb begin
		sel_value = ubb_rst_zero;
		unique case (paddr)
			ubb_off_int_status: sel_value = int_status;
			ubb_off_int_enable: sel_value = int_enable;
			ubb_off_mw_timeout: sel_value = mw_timeout;
			ubb_off_core_setting: sel_value = core_setting;
			ubb_off_master_setting: sel_value = master_setting_reg;
			ubb_off_br_rd_req: sel_value = bridge_read_request_reg;
			ubb_off_br_rd_val: sel_value = bridge_read_value_reg;
			ubb_off_core_rd_req: sel_value = core_read_request;
			ubb_off_core_rd_val: sel_value = {ubb_core_upper, core_result};
			ubb_off_arbiter_setting: sel_value = arbiter_setting;
			ubb_off_wr_start: sel_value = wr_start;
			ubb_off_wr_end: sel_value = wr_end;
			ubb_off_wr_bus_addr: sel_value = wr_bus_addr;
			ubb_off_rd_start: sel_value = rd_start;
			ubb_off_rd_end: sel_value = rd_end;
			ubb_off_rd_bus_addr: sel_value = rd_bus_addr;
			ubb_off_power_ctl: sel_value = {power_ctl[31:1], pwr_level};
			ubb_off_master_status: sel_value = master_state;
			default: sel_value = ubb_rst_zero;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= ubb_rst_zero;
		end else if (setup && !core_area) begin
			prdata <= sel_value;
		end else if (core_wait && port_done) begin
			prdata <= {ubb_core_upper, core_result};
		end
	end

	// ****************************************************************
	// Setting registers
	// ****************************************************************
	// full-width settings; power_ctl stores bit 0 as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_enable <= ubb_rst_zero;
			mw_timeout <= ubb_rst_zero;
			core_setting <= ubb_rst_zero;
			master_setting_reg <= ubb_rst_zero;
			core_read_request <= ubb_rst_zero;
			arbiter_setting <= ubb_rst_zero;
			wr_start <= ubb_rst_zero;
			wr_end <= ubb_rst_zero;
			rd_start <= ubb_rst_zero;
			rd_end <= ubb_rst_zero;
			power_ctl <= ubb_rst_zero;
		end else if (wr_ok && !core_area) begin
			unique case (paddr)
				ubb_off_int_enable: int_enable <= pwdata;
				ubb_off_mw_timeout: mw_timeout <= pwdata;
				ubb_off_core_setting: core_setting <= pwdata;
				ubb_off_master_setting: master_setting_reg <= pwdata;
				ubb_off_core_rd_req: core_read_request <= pwdata;
				ubb_off_arbiter_setting: arbiter_setting <= pwdata;
				ubb_off_wr_start: wr_start <= pwdata;
				ubb_off_wr_end: wr_end <= pwdata;
				ubb_off_rd_start: rd_start <= pwdata;
				ubb_off_rd_end: rd_end <= pwdata;
				ubb_off_power_ctl: power_ctl <= {pwdata[31:1], 1'b0};
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Indirect bridge read
	// ****************************************************************
	// indirect read path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bridge_read_request_reg <= ubb_rst_zero;
			bridge_read_value_reg <= ubb_rst_zero;
			rd_pending <= 1'b0;
		end else if (wr_ok && !core_area && paddr == ubb_off_br_rd_req) begin
			bridge_read_request_reg <= pwdata;
			rd_pending <= pwdata[ubb_req_go_bit];
		end else if (rd_pending) begin
			rd_pending <= 1'b0;
			bridge_read_request_reg[ubb_req_go_bit] <= 1'b0;
			unique case ({4'h0, bridge_read_request_reg[7:0]})
				ubb_off_wr_current: bridge_read_value_reg <= wr_current_addr;
				ubb_off_rd_current: bridge_read_value_reg <= rd_current_addr;
				ubb_off_timeout_count: bridge_read_value_reg <= timeout_counter;
				default: bridge_read_value_reg <= ubb_rst_zero;
			endcase
		end
	end

	// ****************************************************************
	// Bus power detect synchroniser
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_sync <= 3'h0;
			pwr_level <= 1'b0;
			usb_reset_d <= 1'b0;
		end else begin
			pwr_sync <= {pwr_sync[1:0], bus_power_detect_input};
			if (pwr_sync[2] == pwr_sync[1]) begin
				pwr_level <= pwr_sync[1];
			end
			usb_reset_d <= events.usb_reset;
		end
	end

	// ****************************************************************
	// Interrupt status: set wins over write-one-to-clear
	// ****************************************************************
	always_comb begin
		next_status = int_status;
		if (wr_ok && !core_area && paddr == ubb_off_int_status) begin
			next_status = int_status & ~pwdata;
		end
		if (events.wr_ep_err) next_status[ubb_bit_wr_ep_err] = 1'b1;
		if (pwr_sync[2] == pwr_sync[1] && pwr_sync[1] != pwr_level) begin
			next_status[ubb_bit_power] = 1'b1;
		end
		if (rd_pending) next_status[ubb_bit_br_rd_done] = 1'b1;
		if (port_done) next_status[ubb_bit_core_done] = 1'b1;
		if (events.rd_bus_err) next_status[ubb_bit_rd_bus_err] = 1'b1;
		if (events.usb_reset && !usb_reset_d) next_status[ubb_bit_usb_reset] = 1'b1;
		next_status = next_status & ubb_status_mask;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= ubb_rst_zero;
			irq <= 1'b0;
		end else begin
			int_status <= next_status;
			irq <= |(next_status & int_enable);
		end
	end
endmodule

// File: sim/ubb_regs_chk.sv
// Checker: bus answer and core forwarding properties of the bridge registers
`timescale 1ns/1ns
module ubb_regs_chk
	import ubb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire ubb_core_req_s core_req,
	input wire ubb_core_rsp_s core_rsp
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic bset;
	logic cset;
	logic rdone;
	assign bset = psel && !penable && paddr < ubb_core_base;
	assign cset = psel && !penable && paddr >= ubb_core_base;
	assign rdone = pready && psel && !pwrite;
	// ****
	// Properties
	// ****
	property p_br_ready;
		bset |=> pready;
	endproperty
	a_br_ready: assert property (p_br_ready) else $error("bridge access late");
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready too long");
	property p_fwd;
		cset |=> core_req.req && core_req.addr == $past(paddr[9:2]) && core_req.wr == $past(pwrite);
	endproperty
	a_fwd: assert property (p_fwd) else $error("core request missing");
	property p_hold;
		core_req.req && !core_rsp.done |=> core_req.req && $stable(core_req.addr);
	endproperty
	a_hold: assert property (p_hold) else $error("core request dropped");
	property p_drop;
		core_req.req && core_rsp.done |=> !core_req.req ##1 pready;
	endproperty
	a_drop: assert property (p_drop) else $error("core finish wrong");
	property p_bound;
		cset |-> ##[3:20] pready;
	endproperty
	a_bound: assert property (p_bound) else $error("core access not answered");
	property p_upper;
		rdone && paddr >= ubb_core_base |-> prdata[31:16] == ubb_core_upper;
	endproperty
	a_upper: assert property (p_upper) else $error("core word upper half");
	property p_unused;
		rdone && paddr == ubb_off_int_status |-> (prdata & ~ubb_status_mask) == 32'h00000000;
	endproperty
	a_unused: assert property (p_unused) else $error("unused status bit set");
	property p_core_val;
		rdone && paddr == ubb_off_core_rd_val |-> prdata[31:16] == ubb_core_upper;
	endproperty
	a_core_val: assert property (p_core_val) else $error("core value upper half");
	property p_noerr;
		pready |-> !pslverr;
	endproperty
	a_noerr: assert property (p_noerr) else $error("error response");
endmodule
bind ubb_regs ubb_regs_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .core_req(core_req), .core_rsp(core_rsp));

// File: sim/ubb_core_model.sv
// Device core model: 16-bit register words answered after a set latency
`timescale 1ns/1ns
module ubb_core_model
	import ubb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] lat,
	input wire ubb_core_req_s core_req,
	output ubb_core_rsp_s core_rsp
);
	logic [15:0] mem [256];
	logic [3:0] cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_rsp <= '0;
			cnt <= '0;
		end else begin
			core_rsp.done <= 1'b0;
			core_rsp.rdata <= ~core_rsp.rdata;
			if (core_req.req && !core_rsp.done) begin
				if (cnt == lat) begin
					cnt <= '0;
					core_rsp.done <= 1'b1;
					core_rsp.rdata <= mem[core_req.addr];
					if (core_req.wr) mem[core_req.addr] <= core_req.wdata;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule

// File: sim/usb_device_bridge_regs_tb_top.sv
// Testbench: register table, indirect reads, core forwarding and interrupts
`timescale 1ns/1ns
module usb_device_bridge_regs_tb_top;
	import ubb_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic bus_power_detect_input = 0;
	logic pready, pslverr, irq;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] lat = '0;
	ubb_events_s events = '0;
	ubb_core_req_s core_req;
	ubb_core_rsp_s core_rsp;
	logic [31:0] so [9];
	localparam logic [31:0] sexp [9] = '{32'hA5A55A5F, 32'h12345678, 32'h87654321,
		32'h0F0FF0F0, 32'hFFFFFFFC, 32'h80000004, 32'h3C3CC3C3, 32'h0000FFFF, 32'hFFFFFFFE};
	int errors = 0, compares = 0;
	localparam logic [31:0] cur [3] = '{32'h13579BDF, 32'h2468ACE0, 32'h00003C3C};
	localparam logic [7:0] ind [3] = '{8'h48, 8'h58, 8'h88};
	localparam int ebit [3] = '{9, 23, 29};
	localparam logic [75:0] rows [13] = '{{12'h008, 32'hA5A55A5F, 32'hA5A55A5F},
		{12'h00C, 32'h12345678, 32'h12345678}, {12'h010, 32'h87654321, 32'h87654321},
		{12'h03C, 32'h0F0FF0F0, 32'h0F0FF0F0}, {12'h040, 32'hFFFFFFFC, 32'hFFFFFFFC},
		{12'h044, 32'h80000004, 32'h80000004}, {12'h050, 32'h3C3CC3C3, 32'h3C3CC3C3},
		{12'h054, 32'h0000FFFF, 32'h0000FFFF}, {12'h004, 32'hFFFFFFFF, 32'hFFFFFFFF},
		{12'h04C, 32'hDEADBEEF, 32'h00001000}, {12'h05C, 32'hDEADBEEF, 32'h00002000},
		{12'h080, 32'hFFFFFFFF, 32'hFFFFFFFE}, {12'h084, 32'h00000000, 32'h0BADF00D}};
	always #2 pclk = ~pclk;
	ubb_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .bus_power_detect_input(bus_power_detect_input),
		.events(events), .wr_current_addr(cur[0]), .rd_current_addr(cur[1]),
		.wr_bus_addr(32'h00001000), .rd_bus_addr(32'h00002000), .master_state(32'h0BADF00D),
		.timeout_counter(cur[2]), .mw_timeout(so[0]), .core_setting(so[1]),
		.master_setting_reg(so[2]), .arbiter_setting(so[3]), .wr_start(so[4]),
		.wr_end(so[5]), .rd_start(so[6]), .rd_end(so[7]), .power_ctl(so[8]),
		.core_req(core_req), .core_rsp(core_rsp));
	ubb_core_model i_core (.pclk(pclk), .presetn(presetn), .lat(lat), .core_req(core_req),
		.core_rsp(core_rsp));
	// ****
	// Tasks
	// ****
	task automatic complete_run();
		if (errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		if (n >= 50) begin
			chk(32'h0, 32'h1);
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic evt(input int b, input logic ie);
		int n;
		n = 0;
		rd = '0;
		while (rd[b] !== 1'b1 && n < 20) begin
			apb(1'b0, ubb_off_int_status, 32'h0, rd);
			n++;
		end
		chk({31'h0, rd[b]}, 32'h1);
		chk({31'h0, irq}, {31'h0, ie});
		apb(1'b1, ubb_off_int_status, 32'h1 << b, rd);
		apb(1'b0, ubb_off_int_status, 32'h0, rd);
		chk(rd & (32'h1 << b), 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ubb_off_int_status, 32'h0, rd);
		chk(rd, ubb_rst_zero);
		for (int i = 0; i < 13; i++) begin
			apb(1'b1, rows[i][75:64], rows[i][63:32], rd);
			apb(1'b0, rows[i][75:64], 32'h0, rd);
			chk(rd, rows[i][31:0]);
		end
		for (int j = 0; j < 9; j++) begin
			chk(so[j], sexp[j]);
		end
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, ubb_off_br_rd_req, {24'h800000, ind[i]}, rd);
			evt(ubb_bit_br_rd_done, 1'b1);
			apb(1'b0, ubb_off_br_rd_val, 32'h0, rd);
			chk(rd, cur[i]);
		end
		for (int i = 0; i < 2; i++) begin
			lat <= 4'(i * 5);
			apb(1'b1, 12'h208 + 12'(i * 4), 32'hFFFF0000 | 32'(16'hBE00 + i), rd);
			evt(ubb_bit_core_done, 1'b1);
			apb(1'b0, 12'h208 + 12'(i * 4), 32'h0, rd);
			chk(rd, 32'(16'hBE00 + i));
			apb(1'b0, ubb_off_core_rd_val, 32'h0, rd);
			chk(rd, 32'(16'hBE00 + i));
			evt(ubb_bit_core_done, 1'b1);
		end
		for (int i = 0; i < 3; i++) begin
			events <= ubb_events_s'(3'b001 << i);
			@(posedge pclk);
			events <= '0;
			@(posedge pclk);
			evt(ebit[i], 1'b1);
		end
		bus_power_detect_input <= 1'b1;
		evt(ubb_bit_power, 1'b1);
		apb(1'b1, ubb_off_int_enable, 32'h0, rd);
		bus_power_detect_input <= 1'b0;
		evt(ubb_bit_power, 1'b0);
		// Mid-run reset: outputs clear at once, settings back to zero
		presetn <= 1'b0;
		@(posedge pclk);
		chk(so[2] | prdata, 32'h0);
		chk({30'h0, pready, irq}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ubb_off_master_setting, 32'h0, rd);
		chk(rd, ubb_rst_zero);
		complete_run();
	end
endmodule
